// [verilog/link_timing_params.svh]
// Constants for the serial link timing block
`ifndef LINK_TIMING_PARAMS_SVH
`define LINK_TIMING_PARAMS_SVH
// SYSREF latched to LMFC boundary, in input clock cycles per divide ratio
`define SYSREF_LMFC_DIV1 5'd4
`define SYSREF_LMFC_DIV2 5'd10
`define SYSREF_LMFC_DIV4 5'd18
// Divide ratio codes on input_clock_divide_ratio
`define RATIO_DIV1 2'h0
`define RATIO_DIV2 2'h1
`define RATIO_DIV4 2'h2
// Delay stages behind the sequencer; the first frame starts 6 frames after LMFC (window 5.6 to 7.6)
`define LMFC_TO_LANE_FRAMES 7
// SYNCb must be stable this many frames before the boundary
`define SYNCB_SETUP_FRAMES 3
// Frames of SYNCb assertion that request a resynchronization
`define SYNCB_RESYNC_FRAMES 3'd4
// Multiframes of alignment sequence
`define ILA_MULTIFRAMES 3'd4
// Control characters
`define CHAR_K28_5 8'hbc
`define CHAR_K28_0 8'h1c
`define CHAR_K28_3 8'h7c
`endif

// [verilog/link_timing_pkg.sv]
// Types shared by the serial link timing block
package link_timing_pkg;
  typedef enum logic [1:0] {sym_k, sym_ila, sym_data} sym_t;
  typedef enum logic [1:0] {st_cgs, st_ila, st_data} link_state_t;
endpackage

// [verilog/lane_frame_if.sv]
// Frame stream carried from the sequencer into the output delay line
`timescale 1ns/1ps
interface lane_frame_if;
  import link_timing_pkg::*;
  logic adv;
  sym_t in_sym;
  logic [15:0] in_word;
  logic in_first;
  sym_t out_sym;
  logic [15:0] out_word;
  logic out_first;
  modport src (output adv, output in_sym, output in_word, output in_first,
               input out_sym, input out_word, input out_first);
  modport dly (input adv, input in_sym, input in_word, input in_first,
               output out_sym, output out_word, output out_first);
endinterface

// [verilog/lane_delay_line.sv]
// Fixed frame-count delay between the LMFC-aligned sequencer and the lane output
`timescale 1ns/1ps
`include "link_timing_params.svh"
module lane_delay_line
  import link_timing_pkg::*;
#(
  parameter int DEPTH = `LMFC_TO_LANE_FRAMES
)
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ce,
  // Frame stream
  lane_frame_if.dly fr
);
  // ********************************
  // Delay stages
  // ********************************
  sym_t sym_q [DEPTH];
  logic [15:0] word_q [DEPTH];
  logic first_q [DEPTH];
  sym_t next_sym [DEPTH];
  logic [15:0] next_word [DEPTH];
  logic next_first [DEPTH];

  // Refuse a delay line with no stage at elaboration
  if (DEPTH < 1)
  begin : g_bad_depth
    $error("lane_delay_line: DEPTH must be at least 1");
  end

  // Shift one stage per frame; holding between frames keeps latency exact in frames
  always_comb
  begin
    for (int i = 0; i < DEPTH; i++)
    begin
      next_sym[i] = sym_q[i];
      next_word[i] = word_q[i];
      next_first[i] = first_q[i];
    end
    if (fr.adv)
    begin
      next_sym[0] = fr.in_sym;
      next_word[0] = fr.in_word;
      next_first[0] = fr.in_first;
      for (int i = 1; i < DEPTH; i++)
      begin
        next_sym[i] = sym_q[i-1];
        next_word[i] = word_q[i-1];
        next_first[i] = first_q[i-1];
      end
    end
  end

  // Register stages
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < DEPTH; i++)
      begin
        sym_q[i] <= sym_k;
        word_q[i] <= 16'h0000;
        first_q[i] <= 1'b0;
      end
    end
    else if (ce)
    begin
      for (int i = 0; i < DEPTH; i++)
      begin
        sym_q[i] <= next_sym[i];
        word_q[i] <= next_word[i];
        first_q[i] <= next_first[i];
      end
    end
  end

  assign fr.out_sym = sym_q[DEPTH-1];
  assign fr.out_word = word_q[DEPTH-1];
  assign fr.out_first = first_q[DEPTH-1];
endmodule

// [verilog/serial_link_sync_timing.sv]
// LMFC alignment, SYNCb handling and lane sequencing for a subclass-1 link transmitter
`timescale 1ns/1ps
`include "link_timing_params.svh"
// Functional notes
// - LMFC aligns 4/10/18 input clocks after SYSREF
// - First K28.5 frame 5.6-7.6 frames after LMFC
// - First ILA frame 5.6-7.6 frames after LMFC
// - First data frame 5.6-7.6 frames after LMFC
// - SYNCb asserted 4 frames requests resynchronization
// - Alignment sequence lasts exactly 4 multiframes
// - Frame clock period equals sampling period
// - SYNCb sample picks ILA start multiframe
module serial_link_sync_timing
  import link_timing_pkg::*;
#(
  parameter int FRAMES_PER_MF = 32
)
(
  // Clock, reset and enable
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ce,
  // Configuration
  input wire logic [1:0] input_clock_divide_ratio,
  // Link pins from the receiver
  input wire logic sysref,
  input wire logic syncb_n,
  // Sample input
  input wire logic [15:0] sample_in,
  output logic sample_take,
  // Lane output
  output logic lane_valid,
  output sym_t lane_sym,
  output logic [15:0] lane_word,
  output logic lane_mf_start,
  // Timing markers
  output logic lmfc_pulse,
  output logic link_in_data
);
  localparam int FW = $clog2(FRAMES_PER_MF);

  // Refuse multiframe sizes the SYNCb sample point and frame counter cannot serve
  if (FRAMES_PER_MF < 4 || FRAMES_PER_MF > 256)
  begin : g_bad_mf
    $error("serial_link_sync_timing: FRAMES_PER_MF must be 4..256");
  end

  // ********************************
  // Helpers
  // ********************************
  // Last divider count of a frame (input clocks per frame minus one) for a divide code
  function automatic logic [1:0] div_last(input logic [1:0] r);
    unique case (r)
      `RATIO_DIV2: div_last = 2'd1;
      `RATIO_DIV4: div_last = 2'd3;
      default: div_last = 2'd0;
    endcase
  endfunction

  // SYSREF to LMFC delay, minus one for a down-counter ending at zero
  function automatic logic [4:0] align_load(input logic [1:0] r);
    unique case (r)
      `RATIO_DIV2: align_load = `SYSREF_LMFC_DIV2 - 5'd1;
      `RATIO_DIV4: align_load = `SYSREF_LMFC_DIV4 - 5'd1;
      default: align_load = `SYSREF_LMFC_DIV1 - 5'd1;
    endcase
  endfunction

  // ********************************
  // Pin synchronisers
  // ********************************
  logic [2:0] sysref_sr, syncb_sr, next_sysref_sr, next_syncb_sr;
  logic sysref_lvl, syncb_lvl, next_sysref_lvl, next_syncb_lvl;

  // A change counts only when the last two stages agree; stage one feeds stage two only
  always_comb
  begin
    next_sysref_sr = {sysref_sr[1:0], sysref};
    next_syncb_sr = {syncb_sr[1:0], syncb_n};
    next_sysref_lvl = (sysref_sr[1] == sysref_sr[2]) ? sysref_sr[2] : sysref_lvl;
    next_syncb_lvl = (syncb_sr[1] == syncb_sr[2]) ? syncb_sr[2] : syncb_lvl;
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sysref_sr <= 3'h0;
      syncb_sr <= 3'h0;
      sysref_lvl <= 1'b0;
      syncb_lvl <= 1'b0;
    end
    else if (ce)
    begin
      sysref_sr <= next_sysref_sr;
      syncb_sr <= next_syncb_sr;
      sysref_lvl <= next_sysref_lvl;
      syncb_lvl <= next_syncb_lvl;
    end
  end

  // ********************************
  // Frame and LMFC timing
  // ********************************
  logic sysref_prev, align_busy, next_align_busy;
  logic [4:0] align_cnt, next_align_cnt;
  logic [1:0] div_cnt, next_div_cnt;
  logic [FW-1:0] frame_cnt, next_frame_cnt;
  logic frame_tick, boundary, realign, next_lmfc_pulse;

  // One frame per divided clock, so each frame carries one sample
  assign frame_tick = (div_cnt == div_last(input_clock_divide_ratio));
  assign boundary = frame_tick && (frame_cnt == FW'(FRAMES_PER_MF - 1));
  assign realign = align_busy && (align_cnt == 5'd0);

  // SYSREF edge starts a fixed countdown that restarts the frame and LMFC phase.
  // Pulse widths are the sender's duty; a 2-frame pulse always outlasts the filter.
  always_comb
  begin
    next_align_busy = align_busy;
    next_align_cnt = align_cnt;
    next_div_cnt = frame_tick ? 2'd0 : div_cnt + 2'd1;
    next_frame_cnt = frame_cnt;
    if (frame_tick)
      next_frame_cnt = boundary ? '0 : frame_cnt + FW'(1);
    if (sysref_lvl && !sysref_prev)
    begin
      next_align_busy = 1'b1;
      next_align_cnt = align_load(input_clock_divide_ratio);
    end
    else if (realign)
    begin
      next_align_busy = 1'b0;
      next_div_cnt = 2'd0;
      next_frame_cnt = '0;
    end
    else if (align_busy)
      next_align_cnt = align_cnt - 5'd1;
    next_lmfc_pulse = realign || (boundary && !align_busy);
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sysref_prev <= 1'b0;
      align_busy <= 1'b0;
      align_cnt <= 5'd0;
      div_cnt <= 2'd0;
      frame_cnt <= '0;
      lmfc_pulse <= 1'b0;
    end
    else if (ce)
    begin
      sysref_prev <= sysref_lvl;
      align_busy <= next_align_busy;
      align_cnt <= next_align_cnt;
      div_cnt <= next_div_cnt;
      frame_cnt <= next_frame_cnt;
      lmfc_pulse <= next_lmfc_pulse;
    end
  end

  // ********************************
  // Link sequencer
  // ********************************
  link_state_t state, next_state;
  logic syncb_at_lmfc, next_syncb_at_lmfc;
  logic [2:0] assert_run, next_assert_run;
  logic resync_req, next_resync_req;
  logic [1:0] ila_mf, next_ila_mf;
  sym_t frame_sym;
  logic [15:0] frame_word;
  lane_frame_if fr ();

  // Decisions take effect at LMFC boundaries only, keeping latency deterministic
  always_comb
  begin
    next_state = state;
    next_ila_mf = ila_mf;
    next_syncb_at_lmfc = syncb_at_lmfc;
    next_assert_run = assert_run;
    next_resync_req = resync_req;
    if (frame_tick)
    begin
      // Sample the level the receiver set up 3 frames ahead; hold of 0 is enough
      if (frame_cnt == FW'(FRAMES_PER_MF - 1 - `SYNCB_SETUP_FRAMES))
        next_syncb_at_lmfc = !syncb_lvl;
      // Count asserted frames; 4 in a row outside CGS is a resync request
      if (syncb_lvl)
        next_assert_run = 3'd0;
      else if (assert_run != `SYNCB_RESYNC_FRAMES)
        next_assert_run = assert_run + 3'd1;
      if (next_assert_run == `SYNCB_RESYNC_FRAMES && state != st_cgs)
        next_resync_req = 1'b1;
    end
    if (boundary)
    begin
      unique case (state)
        st_cgs:
          if (!syncb_at_lmfc)
          begin
            next_state = st_ila;
            next_ila_mf = 2'd0;
          end
        st_ila:
          if ({1'b0, ila_mf} == `ILA_MULTIFRAMES - 3'd1)
            next_state = st_data;
          else
            next_ila_mf = ila_mf + 2'd1;
        st_data: ;
      endcase
      if (resync_req)
      begin
        next_state = st_cgs;
        next_resync_req = 1'b0;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= st_cgs;
      ila_mf <= 2'd0;
      syncb_at_lmfc <= 1'b1;
      assert_run <= 3'd0;
      resync_req <= 1'b0;
    end
    else if (ce)
    begin
      state <= next_state;
      ila_mf <= next_ila_mf;
      syncb_at_lmfc <= next_syncb_at_lmfc;
      assert_run <= next_assert_run;
      resync_req <= next_resync_req;
    end
  end

  // Content of the frame that starts after this tick, framed by the next state
  always_comb
  begin
    frame_sym = sym_k;
    frame_word = {`CHAR_K28_5, `CHAR_K28_5};
    unique case (next_state)
      st_ila:
      begin
        frame_sym = sym_ila;
        if (boundary)
          frame_word = {`CHAR_K28_0, 6'h00, next_ila_mf};
        else if (next_frame_cnt == FW'(FRAMES_PER_MF - 1))
          frame_word = {`CHAR_K28_3, `CHAR_K28_3};
        else
          frame_word = 16'(next_frame_cnt);
      end
      st_data:
      begin
        frame_sym = sym_data;
        frame_word = sample_in;
      end
      st_cgs: ;
    endcase
  end

  // ********************************
  // Output delay and lane port
  // ********************************
  // Seven delay stages put every first K, ILA or data frame 6 frames after LMFC
  assign fr.adv = frame_tick;
  assign fr.in_sym = frame_sym;
  assign fr.in_word = frame_word;
  assign fr.in_first = boundary;

  lane_delay_line #(.DEPTH(`LMFC_TO_LANE_FRAMES)) u_delay (
    .mclk(mclk),
    .rst_n(rst_n),
    .ce(ce),
    .fr(fr)
  );

  assign sample_take = ce && frame_tick && (next_state == st_data);
  assign lane_valid = ce && frame_tick;
  assign lane_sym = fr.out_sym;
  assign lane_word = fr.out_word;
  assign lane_mf_start = fr.out_first;
  assign link_in_data = (state == st_data);
endmodule

// [verif/serial_link_sync_timing_checker.sv]
// Port-level timing checks for the link timing block
`timescale 1ns/1ps
`include "link_timing_params.svh"
module serial_link_sync_timing_checker
  import link_timing_pkg::*;
#(
  parameter int FRAMES_PER_MF = 32
)
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Watched ports
  input wire logic [1:0] input_clock_divide_ratio,
  input wire logic sample_take,
  input wire logic lane_valid,
  input wire sym_t lane_sym,
  input wire logic [15:0] lane_word,
  input wire logic lane_mf_start,
  input wire logic lmfc_pulse
);
  sym_t prev_sym;
  logic [15:0] prev_word;
  logic [15:0] ila_cnt;
  logic [3:0] up_cnt;
  logic ready;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // Last frame seen; frames flushed from the delay line after reset are skipped
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prev_sym <= sym_k;
      prev_word <= 16'h0;
      ila_cnt <= 16'h0;
      up_cnt <= 4'h0;
    end
    else if (lane_valid)
    begin
      prev_sym <= lane_sym;
      prev_word <= lane_word;
      ila_cnt <= (lane_sym == sym_ila) ? ila_cnt + 16'h1 : 16'h0;
      up_cnt <= (up_cnt == 4'hf) ? up_cnt : up_cnt + 4'h1;
    end
  end
  assign ready = up_cnt == 4'hf;
  frame_div1_a: assert property (input_clock_divide_ratio == 2'h0 && lane_valid |=> lane_valid)
    else $error("frame spacing wrong at divide by 1");
  // A realignment restarts the frame phase, so a frame spanning an LMFC pulse may run long
  frame_div2_a: assert property (disable iff (!rst_n || lmfc_pulse)
    input_clock_divide_ratio == 2'h1 && lane_valid |=> !lane_valid ##1 lane_valid)
    else $error("frame spacing wrong at divide by 2");
  frame_div4_a: assert property (disable iff (!rst_n || lmfc_pulse)
    input_clock_divide_ratio == 2'h2 && lane_valid |=> !lane_valid [*3] ##1 lane_valid)
    else $error("frame spacing wrong at divide by 4");
  take_once_a: assert property (input_clock_divide_ratio == 2'h2 && sample_take |=> !sample_take [*3])
    else $error("more than one sample per frame");
  k_word_a: assert property (ready && lane_valid && lane_sym == sym_k |-> lane_word == {2{`CHAR_K28_5}})
    else $error("sync frame word wrong");
  ila_start_a: assert property (ready && lane_valid && lane_sym == sym_ila && prev_sym == sym_k
    |-> lane_mf_start && lane_word[15:8] == `CHAR_K28_0)
    else $error("alignment sequence start wrong");
  data_start_a: assert property (ready && lane_valid && lane_sym == sym_data && prev_sym != sym_data
    |-> prev_sym == sym_ila && prev_word == {2{`CHAR_K28_3}} && lane_mf_start)
    else $error("data start wrong");
  ila_length_a: assert property (ready && lane_valid && lane_sym == sym_data && prev_sym == sym_ila
    |-> ila_cnt == 16'(4 * FRAMES_PER_MF))
    else $error("alignment sequence length wrong");
endmodule

// [verif/link_receiver_model.sv]
// Receiver-side model driving the reference and sync pins
`timescale 1ns/1ps
module link_receiver_model
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Bench commands and device timing
  input wire logic sysref_req,
  input wire logic sync_req,
  input wire logic lmfc_pulse,
  // Link pins
  output logic sysref,
  output logic syncb_n
);
  logic [5:0] sr_cnt;
  // Pulse of 16 high then 16 low: four frames even at divide by 4, so no request is lost
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      sr_cnt <= 6'h0;
    else if (sr_cnt != 6'h0)
      sr_cnt <= sr_cnt - 6'h1;
    else if (sysref_req)
      sr_cnt <= 6'h20;
  end
  assign sysref = sr_cnt > 6'h10;
  // Sync moves just after a boundary: a whole multiframe of setup, held past the next one
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      syncb_n <= 1'b0;
    else if (lmfc_pulse)
      syncb_n <= !sync_req;
  end
endmodule

// [verif/test_serial_link_sync_timing.sv]
// Self-checking bench for the link timing block
`timescale 1ns/1ps
module test_serial_link_sync_timing;
  import link_timing_pkg::*;
  localparam int K = 32;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [1:0] ratio = 2'h0;
  logic sysref_req = 1'b0;
  logic sync_req = 1'b1;
  logic [15:0] sample_in = 16'h0;
  logic sysref, syncb_n, sample_take, lane_valid, lane_mf_start, lmfc_pulse, link_in_data;
  sym_t lane_sym;
  logic [15:0] lane_word;
  logic [15:0] pw;
  logic in_run = 1'b0;
  int n_mismatch = 0;
  int n_checks = 0;
  int cyc = 0;
  int last_pulse = 0;
  int ph[4];
  initial forever #5 mclk = ~mclk;
  serial_link_sync_timing #(.FRAMES_PER_MF(K)) dut_u (.mclk(mclk), .rst_n(rst_n), .ce(1'b1),
    .input_clock_divide_ratio(ratio), .sysref(sysref), .syncb_n(syncb_n), .sample_in(sample_in),
    .sample_take(sample_take), .lane_valid(lane_valid), .lane_sym(lane_sym), .lane_word(lane_word),
    .lane_mf_start(lane_mf_start), .lmfc_pulse(lmfc_pulse), .link_in_data(link_in_data));
  link_receiver_model rx_u (.mclk(mclk), .rst_n(rst_n), .sysref_req(sysref_req), .sync_req(sync_req),
    .lmfc_pulse(lmfc_pulse), .sysref(sysref), .syncb_n(syncb_n));
  task check_val(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("unexpected %s: expected %0h, seen %0h", what, exp, got);
    end
  endtask
  task summarize;
    $display("checks %0d, mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Cycle count, sample source and hang limit
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (sample_take === 1'b1)
      sample_in <= sample_in + 16'h1;
    if (cyc == 60000)
    begin
      n_mismatch++;
      summarize();
    end
  end
  // Settled view: boundary times and sample continuity of data frames
  always @(negedge mclk)
  begin
    if (lmfc_pulse === 1'b1)
      last_pulse = cyc;
    if (lane_valid === 1'b1 && lane_sym === sym_data)
    begin
      if (in_run)
        check_val("data word", pw + 16'h1, lane_word);
      in_run = 1'b1;
      pw = lane_word;
    end
    else if (lane_valid === 1'b1)
      in_run = 1'b0;
  end
  task reset_dut(input logic [1:0] r);
    @(posedge mclk);
    rst_n <= 1'b0;
    ratio <= r;
    sync_req <= 1'b1;
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    in_run = 1'b0;
    repeat (20) @(posedge mclk);
  endtask
  task pulse_sysref(output int t0);
    @(posedge mclk);
    sysref_req <= 1'b1;
    t0 = cyc;
    @(posedge mclk);
    sysref_req <= 1'b0;
  endtask
  // First frame of a kind; d is input clock cycles since the preceding LMFC pulse, -1 on time-out
  task wait_frame(input sym_t s, input int lim, output int d);
    int i;
    i = 0;
    d = -1;
    while (i < lim && d < 0)
    begin
      @(negedge mclk);
      if (lane_valid === 1'b1 && lane_sym === s)
        d = cyc - last_pulse;
      i++;
    end
  endtask
  // Boundary phase after the reference pulse, per ratio; synchroniser delay cancels in the differences
  task test_lmfc_phase;
    int t0;
    int d;
    for (int r = 0; r < 4; r++)
    begin
      reset_dut(r[1:0]);
      pulse_sysref(t0);
      repeat (300) @(posedge mclk);
      ph[r] = (last_pulse - t0) % (K << (r % 3));
      sync_req <= 1'b0;
      wait_frame(sym_data, 2000, d);
      check_val("data reached", 1, d >= 0);
    end
    check_val("ratio 2 shift", 6, ph[1] - ph[0]);
    check_val("ratio 4 shift", 14, ph[2] - ph[0]);
    check_val("ratio code 3 shift", 0, ph[3] - ph[0]);
  endtask
  task test_link_up;
    int t0;
    int d;
    reset_dut(2'h0);
    pulse_sysref(t0);
    repeat (200) @(posedge mclk);
    @(negedge mclk);
    check_val("held in sync", 0, link_in_data);
    sync_req <= 1'b0;
    wait_frame(sym_ila, 300, d);
    check_val("ila delay", 1, d >= 6 && d <= 8);
    wait_frame(sym_data, 400, d);
    check_val("data delay", 1, d >= 6 && d <= 8);
    check_val("in data", 1, link_in_data);
  endtask
  // Resynchronisation request in mid-stream, then a second link-up
  task test_resync;
    int i;
    int d;
    sync_req <= 1'b1;
    i = 0;
    while (link_in_data !== 1'b0 && i < 200)
    begin
      @(negedge mclk);
      i++;
    end
    check_val("resync taken", 0, link_in_data);
    wait_frame(sym_k, 100, d);
    check_val("k delay", 1, d >= 6 && d <= 8);
    sync_req <= 1'b0;
    wait_frame(sym_ila, 300, d);
    check_val("ila again", 1, d >= 6 && d <= 8);
    wait_frame(sym_data, 400, d);
    check_val("data again", 1, d >= 0);
  endtask
  initial
  begin
    test_lmfc_phase();
    test_link_up();
    test_resync();
    summarize();
  end
endmodule
bind serial_link_sync_timing serial_link_sync_timing_checker #(.FRAMES_PER_MF(FRAMES_PER_MF)) chk_u (
  .mclk(mclk), .rst_n(rst_n), .input_clock_divide_ratio(input_clock_divide_ratio), .sample_take(sample_take),
  .lane_valid(lane_valid), .lane_sym(lane_sym), .lane_word(lane_word), .lane_mf_start(lane_mf_start),
  .lmfc_pulse(lmfc_pulse));
